// [verilog/meas_pkg.sv]
package meas_pkg;
  // Register word index; byte address is four times the index
  localparam int          IDX_W          = 10;
  localparam logic [9:0]  IDX_MEAS_CTRL  = 10'h01e;
  localparam logic [9:0]  IDX_CORR_HIGH  = 10'h01f;
  localparam logic [9:0]  IDX_CORR_LOW   = 10'h020;
  localparam logic [9:0]  IDX_OFFS_HIGH  = 10'h021;
  localparam logic [9:0]  IDX_OFFS_LOW   = 10'h022;
  localparam logic [9:0]  IDX_STR_CTRL   = 10'h023;
  localparam logic [9:0]  IDX_STR_VALUE  = 10'h024;
  localparam logic [9:0]  IDX_INT_STATUS = 10'h030;
  localparam logic [9:0]  IDX_INT_MASK   = 10'h031;
  // Measurement control field positions
  localparam int          BIT_OFFS_DONE  = 6;
  localparam int          BIT_OFFS_TRIG  = 5;
  localparam int          BIT_CORR_DONE  = 4;
  localparam int          BIT_AUTOWIPE   = 3;
  localparam int          BIT_AUTO_ON    = 2;
  localparam int          BIT_WIPE       = 1;
  localparam int          BIT_CORR_TRIG  = 0;
  // Strength control field positions
  localparam int          BIT_STR_DONE   = 1;
  localparam int          BIT_STR_TRIG   = 0;
  // Result widths and reset values
  localparam int          CORR_W         = 16;
  localparam int          STR_W          = 8;
  localparam logic [15:0] CORR_RST       = 16'h0000;
  localparam logic [15:0] OFFS_RST       = 16'h0000;
  localparam logic [7:0]  STR_RST        = 8'hff;
  localparam logic        CORR_DONE_RST  = 1'b1;
  localparam logic        OFFS_DONE_RST  = 1'b0;
  localparam logic        STR_DONE_RST   = 1'b1;
  // Interrupt event positions
  localparam int          EV_W           = 3;
  localparam int          EV_CORR        = 0;
  localparam int          EV_OFFS        = 1;
  localparam int          EV_STR         = 2;
  // Bus slave states, Gray along the path
  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_ACK  = 2'b01
  } apb_st_t;
endpackage

// [verilog/meas_unit.sv]
// One measurement: start pulse out, result capture, done flag
module meas_unit
  import meas_pkg::*;
#(
  parameter int         W        = 16,
  parameter logic [W-1:0] RST_VAL = '0,
  parameter logic       DONE_RST = 1'b1
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic         start,
  input  wire logic         wipe,
  input  wire logic         fe_done,
  input  wire logic [W-1:0] fe_value,
  output logic              go,
  output logic              done,
  output logic              evt,
  output logic [W-1:0]      value
);
  typedef struct packed {
    logic [W-1:0] value;  // Held result
    logic         done;   // Finished flag
    logic         go;     // Start pulse to front end
    logic         evt;    // Completion pulse
  } unit_t;

  unit_t s_r;  // Current state
  unit_t s_nxt;  // Next state

  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.go = 1'b0;
    s_nxt.evt = 1'b0;
    // Wipe first, so a same-cycle result still lands
    if (wipe) begin
      s_nxt.value = RST_VAL;
    end
    // Whole word taken in one edge: high and low never mix
    if (fe_done && !s_r.done) begin
      s_nxt.value = fe_value;
      s_nxt.done = 1'b1;
      s_nxt.evt = 1'b1;
    end
    // A new start restarts a running one
    if (start) begin
      s_nxt.done = 1'b0;
      s_nxt.go = 1'b1;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{value: RST_VAL, done: DONE_RST, go: 1'b0, evt: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign go = s_r.go;
  assign done = s_r.done;
  assign evt = s_r.evt;
  assign value = s_r.value;
endmodule

// [verilog/freq_meas_regs.sv]
// Functional notes
// - Offset trigger starts measurement; reads zero; done flag
// - Correction done flag low while running
// - Autowipe clears correction before each auto phase
// - Auto mode corrects on receive entry
// - Wipe bit in receive clears correction
// - Correction trigger starts one correction
// - Correction signed 16 bits, bytes, resets zero
// - Applied correction is value times step
// - Offset signed 16 bits in two bytes
// - Frequency error is offset times step
// - Strength trigger starts strength measurement
// - Strength done low while sampling, resets one
// - Strength result half dB, resets all ones
// - Level is minus result over two
module freq_meas_regs
  import meas_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  output logic                   irq,
  // Receive sequencer, same clock
  input  wire logic              rx_mode,
  // Correction engine
  output logic                   corr_start,
  input  wire logic              corr_done_in,
  input  wire logic [CORR_W-1:0] corr_value_in,
  output logic [CORR_W-1:0]      freq_correction_value,
  // Offset estimator
  output logic                   offs_start,
  input  wire logic              offs_done_in,
  input  wire logic [CORR_W-1:0] offs_value_in,
  // Strength estimator
  output logic                   str_start,
  input  wire logic              str_done_in,
  input  wire logic [STR_W-1:0]  str_value_in
);
  typedef struct packed {
    apb_st_t          st;        // Bus slave phase
    logic [31:0]      rdata;     // Read data
    logic             ready;     // Access acknowledge
    logic             slverr;    // Unmapped access
    logic             autowipe;  // Wipe before auto phase
    logic             auto_on;   // Correct on receive entry
    logic             rx_d;      // Receive mode, delayed
    logic [EV_W-1:0]  status;    // Sticky events
    logic [EV_W-1:0]  mask;      // Interrupt enables
    logic             irq;       // Interrupt level
  } top_t;

  top_t s_r;  // Current state
  top_t s_nxt;  // Next state

  logic [IDX_W-1:0]  idx;         // Word index of paddr
  logic              hit;         // Address decodes
  logic              wr_go;       // Write takes effect now
  logic              rx_rise;     // Receive mode entered
  logic              corr_trig;   // Software correction start
  logic              corr_go;     // Any correction start
  logic              corr_wipe;   // Clear correction value
  logic              offs_trig;   // Offset start
  logic              str_trig;    // Strength start
  logic [31:0]       rd_val;      // Read mux result
  logic [EV_W-1:0]   ev;          // Completion pulses
  logic              corr_done;   // Correction finished
  logic              offs_done;   // Offset finished
  logic              str_done;    // Strength finished
  logic [CORR_W-1:0] offs_value;  // Offset result
  logic [STR_W-1:0]  str_value;   // Strength result

  assign idx = paddr[ADDR_W-1:2];

  // Writes land only on the acknowledged access edge
  assign wr_go = psel && penable && pwrite && s_r.ready && pstrb[0];

  // Rising edge of receive mode
  assign rx_rise = rx_mode && !s_r.rx_d;

  // Trigger decode; zeros written do nothing
  always_comb begin
    corr_trig = 1'b0;
    offs_trig = 1'b0;
    str_trig = 1'b0;
    corr_wipe = 1'b0;
    if (wr_go && idx == IDX_MEAS_CTRL) begin
      corr_trig = pwdata[BIT_CORR_TRIG];
      offs_trig = pwdata[BIT_OFFS_TRIG];
      // Wipe only honoured in receive mode
      corr_wipe = pwdata[BIT_WIPE] && rx_mode;
    end
    if (wr_go && idx == IDX_STR_CTRL) begin
      str_trig = pwdata[BIT_STR_TRIG];
    end
    // Receive entry starts a correction in auto mode
    corr_go = corr_trig || (s_r.auto_on && rx_rise);
    // Autowipe only meaningful with auto mode on
    if (corr_go && s_r.autowipe && s_r.auto_on) begin
      corr_wipe = 1'b1;
    end
  end

  // Frequency correction; value feeds the synthesizer,
  // which scales it by its own frequency step
  meas_unit #(
    .W        (CORR_W),
    .RST_VAL  (CORR_RST),
    .DONE_RST (CORR_DONE_RST)
  ) u_corr (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .start    (corr_go),
    .wipe     (corr_wipe),
    .fe_done  (corr_done_in),
    .fe_value (corr_value_in),
    .go       (corr_start),
    .done     (corr_done),
    .evt      (ev[EV_CORR]),
    .value    (freq_correction_value)
  );

  // Frequency offset estimate
  meas_unit #(
    .W        (CORR_W),
    .RST_VAL  (OFFS_RST),
    .DONE_RST (OFFS_DONE_RST)
  ) u_offs (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .start    (offs_trig),
    .wipe     (1'b0),
    .fe_done  (offs_done_in),
    .fe_value (offs_value_in),
    .go       (offs_start),
    .done     (offs_done),
    .evt      (ev[EV_OFFS]),
    .value    (offs_value)
  );

  // Signal strength, result in half-dB magnitude
  meas_unit #(
    .W        (STR_W),
    .RST_VAL  (STR_RST),
    .DONE_RST (STR_DONE_RST)
  ) u_str (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .start    (str_trig),
    .wipe     (1'b0),
    .fe_done  (str_done_in),
    .fe_value (str_value_in),
    .go       (str_start),
    .done     (str_done),
    .evt      (ev[EV_STR]),
    .value    (str_value)
  );

  // Read mux; unused bits and triggers read zero
  always_comb begin
    rd_val = '0;
    hit = 1'b1;
    case (idx)
      IDX_MEAS_CTRL: begin
        rd_val[BIT_OFFS_DONE] = offs_done;
        rd_val[BIT_CORR_DONE] = corr_done;
        rd_val[BIT_AUTOWIPE] = s_r.autowipe;
        rd_val[BIT_AUTO_ON] = s_r.auto_on;
      end
      // Signed two's complement, high then low byte
      IDX_CORR_HIGH: begin
        rd_val[7:0] = freq_correction_value[15:8];
      end
      IDX_CORR_LOW: begin
        rd_val[7:0] = freq_correction_value[7:0];
      end
      // Software scales by the step to get the error
      IDX_OFFS_HIGH: begin
        rd_val[7:0] = offs_value[15:8];
      end
      IDX_OFFS_LOW: begin
        rd_val[7:0] = offs_value[7:0];
      end
      IDX_STR_CTRL: begin
        rd_val[BIT_STR_DONE] = str_done;
      end
      // Level in dBm is minus this over two
      IDX_STR_VALUE: begin
        rd_val[STR_W-1:0] = str_value;
      end
      IDX_INT_STATUS: begin
        rd_val[EV_W-1:0] = s_r.status;
      end
      IDX_INT_MASK: begin
        rd_val[EV_W-1:0] = s_r.mask;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Bus phases, control bits and interrupt state
  always_comb begin
    s_nxt = s_r;
    s_nxt.rx_d = rx_mode;
    case (s_r.st)
      // Setup seen: answer in the following access cycle
      APB_IDLE: begin
        if (psel && !penable) begin
          s_nxt.st = APB_ACK;
          s_nxt.ready = 1'b1;
          s_nxt.slverr = !hit;
          s_nxt.rdata = pwrite ? 32'h0000_0000 : rd_val;
        end
      end
      APB_ACK: begin
        s_nxt.st = APB_IDLE;
        s_nxt.ready = 1'b0;
        s_nxt.slverr = 1'b0;
      end
      default: begin
        s_nxt.st = APB_IDLE;
        s_nxt.ready = 1'b0;
      end
    endcase
    // Only the two stored control bits take writes
    if (wr_go && idx == IDX_MEAS_CTRL) begin
      s_nxt.autowipe = pwdata[BIT_AUTOWIPE];
      s_nxt.auto_on = pwdata[BIT_AUTO_ON];
    end
    if (wr_go && idx == IDX_INT_MASK) begin
      s_nxt.mask = pwdata[EV_W-1:0];
    end
    // Write one clears; a same-cycle event wins
    if (wr_go && idx == IDX_INT_STATUS) begin
      s_nxt.status = s_r.status & ~pwdata[EV_W-1:0];
    end
    s_nxt.status = s_nxt.status | ev;
    // Level follows the new status without extra lag
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
  end

  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{st: APB_IDLE, rdata: 32'h0000_0000, ready: 1'b0,
               slverr: 1'b0, autowipe: 1'b0, auto_on: 1'b0,
               rx_d: 1'b0, status: '0, mask: '0, irq: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pready = s_r.ready;
  assign prdata = s_r.rdata;
  assign pslverr = s_r.slverr;
  assign irq = s_r.irq;

  // Checks
  logic ctrl_rd;  // Acknowledged read of control
  assign ctrl_rd = psel && penable && !pwrite && pready &&
                   idx == IDX_MEAS_CTRL;

  trig_zero_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    ctrl_rd |-> prdata[BIT_OFFS_TRIG] == 1'b0 &&
                prdata[BIT_WIPE] == 1'b0 &&
                prdata[BIT_CORR_TRIG] == 1'b0)
    else $error("trigger bit read back nonzero");

  offs_start_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    offs_trig |=> offs_start && !offs_done)
    else $error("offset trigger did not start");

  corr_busy_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    corr_start && !corr_done_in |=> !corr_done)
    else $error("correction done not low while running");

  auto_rx_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    s_r.auto_on && rx_mode && !$past(rx_mode) |-> ##1 corr_start)
    else $error("no correction on receive entry");

  manual_rx_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !s_r.auto_on && !corr_trig |=> !corr_start)
    else $error("correction started without trigger");

  wipe_rx_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    wr_go && idx == IDX_MEAS_CTRL && pwdata[BIT_WIPE] &&
    rx_mode && !(corr_done_in && !corr_done)
    |=> freq_correction_value == CORR_RST)
    else $error("wipe in receive did not clear");

  autowipe_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    corr_go && !s_r.autowipe && !corr_wipe &&
    !(corr_done_in && !corr_done)
    |=> $stable(freq_correction_value))
    else $error("correction value lost without wipe");

  str_start_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    str_trig |=> str_start && !str_done ##1
                 !str_done || $past(str_done_in))
    else $error("strength trigger did not start");

  str_result_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    str_done_in && !str_done && !str_trig
    |=> str_done && str_value == $past(str_value_in))
    else $error("strength result not captured");

  // Level must follow an unmasked event at the very next edge
  irq_level_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    |(ev & s_r.mask) && !(wr_go && idx == IDX_INT_MASK)
    |=> irq)
    else $error("interrupt not raised");

  corr_cap_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    corr_done_in && !corr_done && !corr_go
    |=> corr_done && freq_correction_value == $past(corr_value_in))
    else $error("correction word not captured whole");

  cov_auto_c: cover property (
    @(posedge ref_clk) disable iff (!nrst)
    rx_rise && s_r.auto_on && s_r.autowipe);
  cov_offs_c: cover property (
    @(posedge ref_clk) disable iff (!nrst)
    offs_start ##[1:20] offs_done);
  cov_irq_c: cover property (
    @(posedge ref_clk) disable iff (!nrst)
    $rose(irq));
  cov_err_c: cover property (
    @(posedge ref_clk) disable iff (!nrst)
    pready && pslverr);
endmodule

// [test/freq_meas_regs_tb_top.sv]
module freq_meas_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import meas_pkg::*;

  logic        ref_clk       = 1'b0; // 20 MHz clock
  logic        nrst          = 1'b0; // Active low reset
  logic        psel          = 1'b0; // APB request
  logic        penable       = 1'b0;
  logic        pwrite        = 1'b0;
  logic [11:0] paddr         = 12'h000;
  logic [31:0] pwdata        = 32'h0;
  logic [3:0]  pstrb         = 4'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        irq;
  logic        rx_mode       = 1'b0; // Receive mode level
  logic        corr_start;
  logic        corr_done_in  = 1'b0; // Engine completions
  logic [15:0] corr_value_in = 16'h0;
  logic [15:0] freq_correction_value;
  logic        offs_start;
  logic        offs_done_in  = 1'b0;
  logic [15:0] offs_value_in = 16'h0;
  logic        str_start;
  logic        str_done_in   = 1'b0;
  logic [7:0]  str_value_in  = 8'h0;
  int          mismatches    = 0; // Failed comparisons
  int          samples_checked = 0; // All comparisons
  int          cnt[3]        = '{0, 0, 0}; // Start pulses seen
  logic [2:0]  dn            = 3'b101; // Expected done flags
  logic [31:0] d;
  logic        e;
  logic [15:0] v;
  logic [15:0] cv; // Last correction result taken
  int          k;
  int          n0;

  // Clock
  always #25 ref_clk = ~ref_clk;

  freq_meas_regs u_dut (
    .ref_clk               (ref_clk),
    .nrst                  (nrst),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .pstrb                 (pstrb),
    .pready                (pready),
    .prdata                (prdata),
    .pslverr               (pslverr),
    .irq                   (irq),
    .rx_mode               (rx_mode),
    .corr_start            (corr_start),
    .corr_done_in          (corr_done_in),
    .corr_value_in         (corr_value_in),
    .freq_correction_value (freq_correction_value),
    .offs_start            (offs_start),
    .offs_done_in          (offs_done_in),
    .offs_value_in         (offs_value_in),
    .str_start             (str_start),
    .str_done_in           (str_done_in),
    .str_value_in          (str_value_in)
  );

  // Count start pulses of the three measurements
  always @(posedge ref_clk) begin
    if (corr_start === 1'b1) cnt[0]++;
    if (offs_start === 1'b1) cnt[1]++;
    if (str_start === 1'b1) cnt[2]++;
  end

  // Expected measurement control byte
  function automatic logic [31:0] ctrl(logic od, logic cd, logic aw,
                                       logic ao);
    return {25'h0, od, 1'b0, cd, aw, ao, 2'b00};
  endfunction

  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    end
  endtask

  // APB write; an idle cycle follows so strobes never toggle twice
  task automatic wr(input logic [9:0] i, input logic [7:0] dd,
                    input logic s = 1'b1);
    psel    <= 1'b1;
    pwrite  <= 1'b1;
    paddr   <= {i, 2'b00};
    pwdata  <= {24'h0, dd};
    pstrb   <= {3'b000, s};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // APB read; data and error taken at the ready edge
  task automatic rd(input logic [9:0] i, output logic [31:0] q,
                    output logic er);
    psel    <= 1'b1;
    pwrite  <= 1'b0;
    paddr   <= {i, 2'b00};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q  = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Read and compare, error response must stay low
  task automatic rc(input logic [9:0] i, input logic [31:0] x);
    logic [31:0] q;
    logic        er;
    rd(i, q, er);
    chk(q, x);
    chk({31'h0, er}, 32'h0);
  endtask

  // One-cycle completion from an engine; value lines scrambled after
  task automatic fin(input int m, input logic [15:0] val);
    case (m)
      0: begin
        corr_done_in  <= 1'b1;
        corr_value_in <= val;
      end
      1: begin
        offs_done_in  <= 1'b1;
        offs_value_in <= val;
      end
      default: begin
        str_done_in  <= 1'b1;
        str_value_in <= val[7:0];
      end
    endcase
    @(posedge ref_clk);
    {corr_done_in, offs_done_in, str_done_in} <= 3'b000;
    corr_value_in <= ~val;
    offs_value_in <= ~val;
    str_value_in  <= ~val[7:0];
    @(posedge ref_clk);
  endtask

  // Result registers of one measurement
  task automatic res(input int m, input logic [15:0] val);
    case (m)
      0: begin
        rc(IDX_CORR_HIGH, {24'h0, val[15:8]});
        rc(IDX_CORR_LOW, {24'h0, val[7:0]});
        chk({16'h0, freq_correction_value}, {16'h0, val});
      end
      1: begin
        rc(IDX_OFFS_HIGH, {24'h0, val[15:8]});
        rc(IDX_OFFS_LOW, {24'h0, val[7:0]});
      end
      default: rc(IDX_STR_VALUE, {24'h0, val[7:0]});
    endcase
  endtask

  // Ends the run from either the tests or the watchdog
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    n0 = $urandom(32'h5181);
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rc(IDX_MEAS_CTRL, ctrl(1'b0, 1'b1, 1'b0, 1'b0));
    res(0, 16'h0000);
    rc(IDX_STR_CTRL, 32'h2);
    rc(IDX_STR_VALUE, 32'hff);
    rd(10'h3ff, d, e);
    chk({e, d}, {1'b1, 32'h0});
    wr(IDX_INT_MASK, 8'h07);
    $display("test reset done");
    // Corner values first, then random ones
    for (int i = 0; i < 6; i++) begin
      k  = i % 3;
      v  = (i < 3) ? 16'h8000 : 16'($urandom);
      if (k == 0) cv = v;
      n0 = cnt[k];
      dn[k] = 1'b0;
      if (k == 2) wr(IDX_STR_CTRL, 8'h01);
      else wr(IDX_MEAS_CTRL, (k == 0) ? 8'h01 : 8'h20);
      @(posedge ref_clk);
      chk(cnt[k], n0 + 1);
      // Zero write must not disturb the running one
      if (k == 2) wr(IDX_STR_CTRL, 8'h00);
      else wr(IDX_MEAS_CTRL, 8'h00);
      rc(IDX_MEAS_CTRL, ctrl(dn[1], dn[0], 1'b0, 1'b0));
      rc(IDX_STR_CTRL, {30'h0, dn[2], 1'b0});
      chk({31'h0, irq}, 32'h0);
      fin(k, v);
      dn[k] = 1'b1;
      rc(IDX_MEAS_CTRL, ctrl(dn[1], dn[0], 1'b0, 1'b0));
      rc(IDX_STR_CTRL, {30'h0, dn[2], 1'b0});
      res(k, v);
      rc(IDX_INT_STATUS, 32'h1 << k);
      chk({31'h0, irq}, 32'h1);
      // Late completion while idle is ignored
      fin(k, ~v);
      res(k, v);
      wr(IDX_INT_STATUS, 8'(1 << k));
      @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0);
      rc(IDX_INT_STATUS, 32'h0);
    end
    $display("test measurements done");
    // Wipe outside receive mode is ignored
    wr(IDX_MEAS_CTRL, 8'h02);
    res(0, cv);
    n0 = cnt[0];
    rx_mode <= 1'b1;
    wr(IDX_MEAS_CTRL, 8'h02);
    chk(cnt[0], n0);
    res(0, 16'h0000);
    rc(IDX_MEAS_CTRL, ctrl(1'b1, 1'b1, 1'b0, 1'b0));
    $display("test wipe done");
    // Auto correction on receive entry, no wipe
    rx_mode <= 1'b0;
    wr(IDX_MEAS_CTRL, 8'h04);
    fin(0, 16'h7fff);
    rx_mode <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(cnt[0], n0 + 1);
    rc(IDX_MEAS_CTRL, ctrl(1'b1, 1'b0, 1'b0, 1'b1));
    fin(0, v);
    res(0, v);
    // Autowipe with auto mode clears before the new phase
    rx_mode <= 1'b0;
    wr(IDX_MEAS_CTRL, 8'h0c);
    rx_mode <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(cnt[0], n0 + 2);
    chk({16'h0, freq_correction_value}, 32'h0);
    fin(0, 16'h7fff);
    // Autowipe without auto mode keeps the value; the trigger
    // sees the stored mode bits, so auto is turned off first
    wr(IDX_MEAS_CTRL, 8'h08);
    wr(IDX_MEAS_CTRL, 8'h09);
    repeat (2) @(posedge ref_clk);
    chk({16'h0, freq_correction_value}, 32'h7fff);
    fin(0, 16'h7fff);
    rc(IDX_MEAS_CTRL, ctrl(1'b1, 1'b1, 1'b1, 1'b0));
    wr(IDX_MEAS_CTRL, 8'h04, 1'b0);
    rc(IDX_MEAS_CTRL, ctrl(1'b1, 1'b1, 1'b1, 1'b0));
    wr(IDX_INT_STATUS, 8'h07);
    $display("test auto done");
    // Masked event sets status but keeps the line low
    wr(IDX_INT_MASK, 8'h03);
    wr(IDX_STR_CTRL, 8'h01);
    fin(2, 16'h0042);
    @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    rc(IDX_INT_STATUS, 32'h4);
    rc(IDX_STR_VALUE, 32'h42);
    $display("test mask done");
    tally_and_finish;
  end
endmodule
